// ===== rtl/fast_adc_path.v
// Result path of the four-channel fast converter: channel timer, request arbitration,
// channel steering, two cascadable summing stages, final result register, interrupt.
// Assumes an external converter that answers adc_start with one adc_done pulse.
`include "fast_adc_defines.vh"

module fast_adc_path (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata,
    // Convert requests from external triggers
    input wire [3:0] ext_conv_request,
    // Input switch control to the analog front end
    output wire [3:0] chan_pos_connect,
    output wire [3:0] chan_neg_connect,
    // Converter handshake
    output reg adc_start,
    output reg [1:0] adc_chan,
    output reg adc_diff,
    input wire adc_done,
    input wire [9:0] adc_data,
    // Result towards the DMA
    output reg [19:0] result_data,
    output reg [1:0] result_chan,
    output reg new_result,
    // Interrupt
    output wire irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    reg [4:0] ctrl_reg;
    reg [7:0] chan_cfg_reg;
    reg [9:0] stage0_cfg_reg;
    reg [9:0] stage1_cfg_reg;
    reg [1:0] irq_status_reg;
    reg [1:0] irq_status_next;
    reg [1:0] irq_enable_reg;
    reg [14:0] phase_acc_reg;
    reg [3:0] pending_reg;
    reg [3:0] pending_next;
    reg state_reg;
    reg [1:0] cur_chan_reg;
    reg stage_clear_reg;
    reg [1:0] pick;
    reg pick_ok;
    reg overrun;
    integer i;
    integer j;

    wire [1:0] path = ctrl_reg[`CTRL_PATH_LSB+1:`CTRL_PATH_LSB];
    wire timer_en = ctrl_reg[`CTRL_TIMER_BIT];
    wire [1:0] filter_chan = ctrl_reg[`CTRL_FCHAN_LSB+1:`CTRL_FCHAN_LSB];
    wire [14:0] phase_sum = phase_acc_reg + `CONV_KHZ;
    wire timer_tick = timer_en && (phase_sum >= `CLK_KHZ);
    wire [3:0] req_in = ext_conv_request | {3'h0, timer_tick};

    function [1:0] chan_mode;
        input [7:0] cfg;
        input [1:0] ch;
        begin
            chan_mode = cfg[{ch, 1'b0} +: 2];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Analog input switches
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : sw
            // Off leaves both lines open; single-ended uses only the positive line
            assign chan_pos_connect[g] = chan_cfg_reg[2*g +: 2] != `MODE_OFF;
            assign chan_neg_connect[g] = chan_cfg_reg[2*g +: 2] == `MODE_DIFF;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Channel timer: fractional phase accumulator gives an exact average rate even
    // though the clock is not an integer multiple of it, at the cost of 1-cycle jitter
    always @(posedge sys_clk) begin
        if (rst || !timer_en) begin
            phase_acc_reg <= 15'h0000;
        end else if (timer_tick) begin
            phase_acc_reg <= phase_sum - `CLK_KHZ;
        end else begin
            phase_acc_reg <= phase_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request arbitration: lowest connected pending channel wins
    always @* begin
        pick = 2'h0;
        pick_ok = 1'b0;
        for (i = 3; i >= 0; i = i - 1) begin
            if (pending_reg[i] && chan_mode(chan_cfg_reg, i[1:0]) != `MODE_OFF) begin
                pick = i[1:0];
                pick_ok = 1'b1;
            end
        end
    end

    always @* begin
        pending_next = pending_reg;
        overrun = 1'b0;
        if (state_reg == ST_IDLE && pick_ok) begin
            pending_next[pick] = 1'b0;
        end
        // A new request beats the clear of the one being started
        for (j = 0; j < 4; j = j + 1) begin
            if (req_in[j] && chan_mode(chan_cfg_reg, j[1:0]) != `MODE_OFF) begin
                if (pending_reg[j] && !(state_reg == ST_IDLE && pick_ok && pick == j[1:0])) begin
                    overrun = 1'b1;
                end
                pending_next[j] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion sequencing
    always @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            pending_reg <= 4'h0;
            cur_chan_reg <= 2'h0;
            adc_start <= 1'b0;
            adc_chan <= 2'h0;
            adc_diff <= 1'b0;
        end else begin
            pending_reg <= pending_next;
            adc_start <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (pick_ok) begin
                        // Input mux and result steering follow the granted request
                        adc_start <= 1'b1;
                        adc_chan <= pick;
                        adc_diff <= chan_mode(chan_cfg_reg, pick) == `MODE_DIFF;
                        cur_chan_reg <= pick;
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (adc_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Summing stages on the filtered channel
    wire done_now = (state_reg == ST_CONV) && adc_done;
    wire to_filter = done_now && (cur_chan_reg == filter_chan) && (path != `PATH_RAW);
    wire s0_valid;
    wire [`S0_W-1:0] s0_data;
    wire s1_valid;
    wire [`S1_W-1:0] s1_data;

    sum_stage #(.IN_W(`ADC_W), .OUT_W(`S0_W)) first_sum_stage (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(stage_clear_reg),
        .ord(stage0_cfg_reg[`STG_ORD_LSB+5:`STG_ORD_LSB]),
        .dec(stage0_cfg_reg[`STG_DEC_LSB+1:`STG_DEC_LSB-2]),
        .in_valid(to_filter),
        .in_data(adc_data),
        .out_valid(s0_valid),
        .out_data(s0_data)
    );

    // Second stage sees first stage outputs, so runs at its decimated rate
    sum_stage #(.IN_W(`S0_W), .OUT_W(`S1_W)) second_sum_stage (
        .sys_clk(sys_clk),
        .rst(rst),
        .clear(stage_clear_reg),
        .ord(stage1_cfg_reg[`STG_ORD_LSB+5:`STG_ORD_LSB]),
        .dec(stage1_cfg_reg[`STG_DEC_LSB+1:`STG_DEC_LSB-2]),
        .in_valid(s0_valid && path == `PATH_TWO),
        .in_data(s0_data),
        .out_valid(s1_valid),
        .out_data(s1_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Final result register and DMA request
    always @(posedge sys_clk) begin
        if (rst) begin
            result_data <= 20'h00000;
            result_chan <= 2'h0;
            new_result <= 1'b0;
        end else begin
            new_result <= 1'b0;
            if (done_now && !to_filter) begin
                // Raw converter output stays unsigned; signed conversion is downstream
                result_data <= {10'h000, adc_data};
                result_chan <= cur_chan_reg;
                new_result <= 1'b1;
            end else if (s0_valid && path == `PATH_ONE) begin
                result_data <= {5'h00, s0_data};
                result_chan <= filter_chan;
                new_result <= 1'b1;
            end else if (s1_valid && path == `PATH_TWO) begin
                result_data <= s1_data;
                result_chan <= filter_chan;
                new_result <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes and interrupt status
    always @* begin
        irq_status_next = irq_status_reg;
        if (reg_write && reg_addr == `REG_IRQ_CLEAR) begin
            irq_status_next = irq_status_reg & ~reg_wdata[1:0];
        end
        // Events win over a clear in the same cycle
        if (new_result) begin
            irq_status_next[`IRQ_NEW] = 1'b1;
        end
        if (overrun) begin
            irq_status_next[`IRQ_OVERRUN] = 1'b1;
        end
    end

    assign irq = |(irq_status_reg & irq_enable_reg);

    always @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RESET;
            chan_cfg_reg <= `CHAN_CFG_RESET;
            stage0_cfg_reg <= `STG_RESET;
            stage1_cfg_reg <= `STG_RESET;
            irq_status_reg <= 2'h0;
            irq_enable_reg <= 2'h0;
            stage_clear_reg <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            stage_clear_reg <= 1'b0;
            if (reg_write) begin
                if (reg_addr == `REG_CTRL) begin
                    ctrl_reg <= reg_wdata[4:0];
                    stage_clear_reg <= 1'b1;
                end else if (reg_addr == `REG_CHAN_CFG) begin
                    chan_cfg_reg <= reg_wdata[7:0];
                end else if (reg_addr == `REG_STAGE0) begin
                    stage0_cfg_reg <= {reg_wdata[11:8], reg_wdata[5:0]};
                    stage_clear_reg <= 1'b1;
                end else if (reg_addr == `REG_STAGE1) begin
                    stage1_cfg_reg <= {reg_wdata[11:8], reg_wdata[5:0]};
                    stage_clear_reg <= 1'b1;
                end else if (reg_addr == `REG_IRQ_ENABLE) begin
                    irq_enable_reg <= reg_wdata[1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register reads: data in the cycle after the strobe, zero otherwise
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (!reg_read) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_addr == `REG_CTRL) begin
            reg_rdata <= {27'h0000000, ctrl_reg};
        end else if (reg_addr == `REG_CHAN_CFG) begin
            reg_rdata <= {24'h000000, chan_cfg_reg};
        end else if (reg_addr == `REG_STAGE0) begin
            reg_rdata <= {20'h00000, stage0_cfg_reg[9:6], 2'h0, stage0_cfg_reg[5:0]};
        end else if (reg_addr == `REG_STAGE1) begin
            reg_rdata <= {20'h00000, stage1_cfg_reg[9:6], 2'h0, stage1_cfg_reg[5:0]};
        end else if (reg_addr == `REG_RESULT) begin
            reg_rdata <= {6'h00, result_chan, 4'h0, result_data};
        end else if (reg_addr == `REG_IRQ_STATUS) begin
            reg_rdata <= {30'h00000000, irq_status_reg};
        end else if (reg_addr == `REG_IRQ_ENABLE) begin
            reg_rdata <= {30'h00000000, irq_enable_reg};
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // fast_adc_path

// ===== rtl/fast_adc_defines.vh
// Constants for the fast converter result path: register indices, field positions,
// reset values and timing. Assumes a 20 MHz system clock and word-wide register port.
//
// Function
// - Channels single-ended, differential or disconnected
// - Active request picks channel and result path
// - Any connected channel's request starts a conversion
// - Final result stored, new-result event requests DMA
// - Converter output is unsigned positive only
// - Result from raw, one or two stages
// - Channel timer makes 1.2 MHz convert requests
// - Stage sums last M/dec whole groups of dec samples, no multiplier
// - Order M gives nulls at rate/M multiples when dec divides M
// - Second stage runs at first stage output rate
// - Order 1 to 32, decimation 1 to 8
// - Partial sums of dec inputs, summed into output
`ifndef FAST_ADC_DEFINES_VH
`define FAST_ADC_DEFINES_VH

// Register word indices
`define REG_CTRL       4'h0
`define REG_CHAN_CFG   4'h1
`define REG_STAGE0     4'h2
`define REG_STAGE1     4'h3
`define REG_RESULT     4'h4
`define REG_IRQ_STATUS 4'h5
`define REG_IRQ_CLEAR  4'h6
`define REG_IRQ_ENABLE 4'h7

// Control fields
`define CTRL_PATH_LSB    0
`define CTRL_TIMER_BIT   2
`define CTRL_FCHAN_LSB   3
`define CTRL_RESET       5'h00

// Path codes
`define PATH_RAW  2'h0
`define PATH_ONE  2'h1
`define PATH_TWO  2'h2

// Channel modes
`define MODE_OFF  2'h0
`define MODE_SE   2'h1
`define MODE_DIFF 2'h2
`define CHAN_CFG_RESET 8'h00

// Stage config fields: order in [5:0], decimation in [11:8]
`define STG_ORD_LSB  0
`define STG_DEC_LSB  8
`define STG_RESET    10'h041

// Result fields
`define RES_CHAN_LSB 24

// Interrupt bits
`define IRQ_NEW     0
`define IRQ_OVERRUN 1

// Timing: channel timer rate as a fraction of the system clock
`define CLK_KHZ  15'h4E20
`define CONV_KHZ 15'h04B0

// Widths
`define ADC_W   10
`define S0_W    15
`define S1_W    20
`endif

// ===== rtl/partial_sum_memory.v
// Small memory holding the partial sums of one summing stage.
// Synchronous write, registered read; one clock, no reset on the array.
module partial_sum_memory #(
    parameter W = 20
) (
    // Clock
    input wire sys_clk,
    // Write port
    input wire we,
    input wire [4:0] waddr,
    input wire [W-1:0] wdata,
    // Read port
    input wire [4:0] raddr,
    output reg [W-1:0] rdata
);
    reg [W-1:0] mem [0:31];

    always @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // partial_sum_memory

// ===== rtl/sum_stage.v
// One decimating summing stage: groups of dec inputs form a partial sum, the output
// is the running total of the last ord/dec partial sums. Inputs arrive far apart
// (at least three cycles), as they do at converter rates.
module sum_stage #(
    parameter IN_W = 10,
    parameter OUT_W = 15
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    input wire clear,
    // Configuration
    input wire [5:0] ord,
    input wire [3:0] dec,
    // Sample in
    input wire in_valid,
    input wire [IN_W-1:0] in_data,
    // Sample out
    output reg out_valid,
    output reg [OUT_W-1:0] out_data
);
    reg [3:0] grp_reg;
    reg [OUT_W-1:0] acc_reg;
    reg [OUT_W-1:0] psum_reg;
    reg phase_reg;
    reg [4:0] ptr_reg;
    reg [5:0] fill_reg;
    wire [OUT_W-1:0] oldest;
    wire [OUT_W-1:0] in_ext;
    wire [3:0] dec_eff;
    wire [5:0] ord_eff;
    wire [5:0] len_raw;
    wire [5:0] len;
    wire [OUT_W-1:0] mem_rdata;

    // Out-of-range settings fall back to the nearest legal value
    assign dec_eff = (dec == 4'h0) ? 4'h1 : ((dec > 4'h8) ? 4'h8 : dec);
    assign ord_eff = (ord == 6'h00) ? 6'h01 : ((ord > 6'h20) ? 6'h20 : ord);
    // Number of partial sums combined; effective order is group length times this count
    assign len_raw = ord_eff / {2'h0, dec_eff};
    assign len = (len_raw == 6'h00) ? 6'h01 : len_raw;
    assign in_ext = {{(OUT_W-IN_W){1'b0}}, in_data};
    // Until the ring is full the missing history counts as zero
    assign oldest = (fill_reg == len) ? mem_rdata : {OUT_W{1'b0}};

    partial_sum_memory #(.W(OUT_W)) ring (
        .sys_clk(sys_clk),
        .we(phase_reg),
        .waddr(ptr_reg),
        .wdata(psum_reg),
        .raddr(ptr_reg),
        .rdata(mem_rdata)
    );

    always @(posedge sys_clk) begin
        if (rst || clear) begin
            grp_reg <= 4'h0;
            acc_reg <= {OUT_W{1'b0}};
            psum_reg <= {OUT_W{1'b0}};
            phase_reg <= 1'b0;
            ptr_reg <= 5'h00;
            fill_reg <= 6'h00;
            out_valid <= 1'b0;
            out_data <= {OUT_W{1'b0}};
        end else begin
            out_valid <= 1'b0;
            phase_reg <= 1'b0;
            if (in_valid) begin
                if (grp_reg == dec_eff - 4'h1) begin
                    // Group complete: output rate is input rate over dec
                    psum_reg <= acc_reg + in_ext;
                    acc_reg <= {OUT_W{1'b0}};
                    grp_reg <= 4'h0;
                    phase_reg <= 1'b1;
                end else begin
                    acc_reg <= acc_reg + in_ext;
                    grp_reg <= grp_reg + 4'h1;
                end
            end
            if (phase_reg) begin
                // Add newest partial, drop the one len groups old: sum of last len*dec inputs
                out_data <= out_data + psum_reg - oldest;
                out_valid <= 1'b1;
                ptr_reg <= (ptr_reg == len[4:0] - 5'h01) ? 5'h00 : ptr_reg + 5'h01;
                if (fill_reg != len) begin
                    fill_reg <= fill_reg + 6'h01;
                end
            end
        end
    end
endmodule // sum_stage

// ===== test/fast_adc_path_props.sv
// Checker for the fast converter result path: converter handshake, channel
// steering and result event timing. Sees only the top module's ports.
module fast_adc_path_props (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Channel switches
    input wire [3:0] chan_pos_connect,
    input wire [3:0] chan_neg_connect,
    // Converter handshake
    input wire adc_start,
    input wire [1:0] adc_chan,
    input wire adc_diff,
    input wire adc_done,
    // Result
    input wire [19:0] result_data,
    input wire [1:0] result_chan,
    input wire new_result
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // Cycles since the last converter answer; saturates so it cannot wrap
    logic [3:0] since_done;
    always @(posedge sys_clk) begin
        if (rst)
            since_done <= 4'hF;
        else if (adc_done)
            since_done <= 4'h0;
        else if (since_done != 4'hF)
            since_done <= since_done + 4'h1;
    end

    // High from a start until the converter answers
    logic conv_busy;
    always @(posedge sys_clk) begin
        if (rst)
            conv_busy <= 1'b0;
        else if (adc_start)
            conv_busy <= 1'b1;
        else if (adc_done)
            conv_busy <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    new_pulse_a:
        assert property (new_result |=> !new_result) else $error("new_result too long");
    result_cause_a:
        assert property (($changed(result_data) || $changed(result_chan)) |-> new_result)
        else $error("result changed without new_result");
    result_source_a:
        assert property (new_result |-> since_done < 4'h8)
        else $error("new_result without a recent conversion");
    start_pulse_a:
        assert property (adc_start |=> !adc_start) else $error("adc_start too long");
    start_wait_a:
        assert property (adc_start |-> !conv_busy)
        else $error("start while converter busy");
    chan_hold_a:
        assert property (!adc_start |-> $stable(adc_chan) && $stable(adc_diff))
        else $error("channel changed without start");
    start_connected_a:
        assert property (adc_start |-> chan_pos_connect[adc_chan])
        else $error("start on a disconnected channel");
    diff_mode_a:
        assert property (adc_start |-> adc_diff == chan_neg_connect[adc_chan])
        else $error("differential flag does not match channel mode");
    neg_needs_pos_a:
        assert property ((chan_neg_connect & ~chan_pos_connect) == 4'h0)
        else $error("negative line connected alone");
endmodule // fast_adc_path_props

bind fast_adc_path fast_adc_path_props props (.sys_clk, .rst, .chan_pos_connect,
    .chan_neg_connect, .adc_start, .adc_chan, .adc_diff, .adc_done, .result_data,
    .result_chan, .new_result);

// ===== test/conv_model.sv
// Behavioural converter: answers each start with one done pulse after lat+1 cycles.
// Assumes the bench sets sample before the request and lat between conversions.
module conv_model (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Control from the bench
    input wire [3:0] lat,
    input wire [9:0] sample,
    // Converter handshake
    input wire adc_start,
    input wire [1:0] adc_chan,
    output logic adc_done = 1'b0,
    output logic [9:0] adc_data = 10'h000
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [9:0] held = 10'h000;

    always @(posedge sys_clk) begin
        adc_done <= 1'b0;
        // Outside the done cycle the data toggle, so no stale value looks valid
        adc_data <= ~adc_data;
        if (rst) begin
            busy <= 1'b0;
        end else if (adc_start) begin
            busy <= 1'b1;
            cnt <= lat;
            held <= sample;
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            adc_done <= 1'b1;
            adc_data <= held;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule // conv_model

// ===== test/fast_adc_comb_decimator_path_test.sv
// Self-checking bench for the fast converter result path.
// Assumes a converter model on the handshake and a 20 MHz clock.
module fast_adc_comb_decimator_path_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [3:0] ext_conv_request = 4'h0;
    logic [3:0] lat = 4'h2;
    logic [9:0] sample = 10'h000;
    wire [31:0] reg_rdata;
    wire [3:0] chan_pos_connect, chan_neg_connect;
    wire adc_start, adc_diff, adc_done, new_result, irq;
    wire [1:0] adc_chan, result_chan;
    wire [9:0] adc_data;
    wire [19:0] result_data;
    int n_errors = 0;
    int tests_run = 0;
    int n_start = 0;
    logic [21:0] got[$];
    int xs[$], y0[$], y1[$];

    always #25 sys_clk = ~sys_clk;

    fast_adc_path dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .ext_conv_request, .chan_pos_connect, .chan_neg_connect, .adc_start,
        .adc_chan, .adc_diff, .adc_done, .adc_data, .result_data, .result_chan,
        .new_result, .irq);
    conv_model adc (.sys_clk, .rst, .lat, .sample, .adc_start, .adc_chan, .adc_done,
        .adc_data);

    always @(negedge sys_clk) begin
        if (adc_start === 1'b1) n_start++;
        if (new_result === 1'b1) got.push_back({result_chan, result_data});
    end

    ////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task finish_test;
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask

    task pulse(input logic [3:0] req);
        @(posedge sys_clk);
        ext_conv_request <= req;
        @(posedge sys_clk);
        ext_conv_request <= 4'h0;
    endtask

    task conv(input int ch, input logic [9:0] d);
        int n;
        sample <= d;
        pulse(4'(1 << ch));
        n = 0;
        while (adc_done !== 1'b1 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 60) n_errors++;
        // Let the slowest cascade settle before the next input
        repeat (8) @(posedge sys_clk);
    endtask

    // Reference stage: output on every dec-th input, sum of last (ord/dec)*dec
    function automatic void stage(input int xin[$], input int o, input int d,
                                  output int yout[$]);
        int e, s;
        yout = {};
        e = ((o / d < 1) ? 1 : o / d) * d;
        for (int k = d; k <= xin.size(); k += d) begin
            s = 0;
            for (int j = k - e; j < k; j++) if (j >= 0) s += xin[j];
            yout.push_back(s);
        end
    endfunction

    // Consumer side of the result stream
    function automatic int dma_bits(input int path, input int prod);
        return (path == 2 && prod > 64) ? 32 : 16;
    endfunction
    function automatic int to_signed(input logic [19:0] u, input int mid);
        return int'(u) - mid;
    endfunction

    task run_stage(input int o0, input int d0, input int o1, input int d1,
                   input int path, input int cnt);
        int q;
        wr(4'h2, 32'((d0 << 8) | o0));
        wr(4'h3, 32'((d1 << 8) | o1));
        wr(4'h0, 32'(path));
        got = {};
        xs = {};
        repeat (cnt) begin
            q = $urandom % 1024;
            xs.push_back(q);
            lat <= 4'($urandom % 12);
            conv(0, 10'(q));
        end
        stage(xs, o0, d0, y0);
        if (path == 2) stage(y0, o1, d1, y1); else y1 = y0;
        check(32'(got.size()), 32'(y1.size()));
        foreach (y1[i]) check(32'(got[i]), 32'(y1[i]));
        // Level-shift midpoint of the summed samples
        q = 512 * o0 * o1;
        foreach (got[i]) begin
            check(32'(got[i][19:0] >> dma_bits(path, o0 * o1)), 32'h0);
            check(32'(to_signed(got[i][19:0], q) < 0), 32'(y1[i] < q));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int v;
        logic [7:0] c;
        logic [3:0] ep, en;
        v = $urandom(37924);
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h1, 32'h0);
        rd(4'h8, 32'h0);
        for (int i = 0; i < 7; i++) begin
            c = (i == 0) ? 8'hE4 : 8'($urandom);
            wr(4'h1, {24'h0, c});
            for (int k = 0; k < 4; k++) begin
                ep[k] = c[2*k +: 2] != 2'h0;
                en[k] = c[2*k +: 2] == 2'h2;
            end
            #1 check({28'h0, chan_pos_connect}, {28'h0, ep});
            check({28'h0, chan_neg_connect}, {28'h0, en});
        end
        wr(4'h1, 32'h55);
        wr(4'h6, 32'h3);
        wr(4'h7, 32'h1);
        got = {};
        conv(0, 10'h3FF);
        check(32'(got[0]), 32'h3FF);
        rd(4'h4, 32'h3FF);
        check({31'h0, irq}, 32'h1);
        rd(4'h5, 32'h1);
        wr(4'h7, 32'h0);
        #1 check({31'h0, irq}, 32'h0);
        wr(4'h6, 32'h1);
        rd(4'h5, 32'h0);
        // Two channels at once: the lower one is converted first
        got = {};
        lat <= 4'h3;
        sample <= 10'h155;
        pulse(4'h6);
        repeat (40) @(posedge sys_clk);
        check(32'(got.size()), 32'h2);
        check(32'(got[0]), 32'h100155);
        check(32'(got[1]), 32'h200155);
        // Channel 3 switched off: its request is dropped
        wr(4'h1, 32'h15);
        v = n_start;
        pulse(4'h8);
        repeat (20) @(posedge sys_clk);
        check(32'(n_start - v), 32'h0);
        // Repeated request while pending is an overrun, not a second conversion
        wr(4'h1, 32'h55);
        lat <= 4'hF;
        got = {};
        pulse(4'h2);
        pulse(4'h1);
        pulse(4'h1);
        repeat (60) @(posedge sys_clk);
        check(32'(got.size()), 32'h2);
        rd(4'h5, 32'h3);
        wr(4'h6, 32'h3);
        run_stage(8, 2, 1, 1, 1, 40);
        run_stage(1, 1, 1, 1, 1, 24);
        run_stage(32, 8, 1, 1, 1, 48);
        run_stage(7, 2, 1, 1, 1, 30);
        // Reference cascade: 2 * 6 = 1.5 * 8 notch alignment
        run_stage(8, 2, 6, 3, 2, 36);
        run_stage(16, 4, 8, 2, 2, 48);
        run_stage(3, 1, 4, 2, 2, 24);
        wr(4'h0, 32'h9);
        got = {};
        conv(0, 10'h02A);
        conv(1, 10'h011);
        check(32'(got[0]), 32'h02A);
        check(32'(got[1]), 32'h100011);
        // Channel timer: 1200 starts per 20000 cycles
        wr(4'h0, 32'h4);
        lat <= 4'h2;
        v = n_start;
        repeat (2000) @(posedge sys_clk);
        v = n_start - v;
        check({31'h0, v >= 119 && v <= 121}, 32'h1);
        wr(4'h0, 32'h0);
        finish_test;
    end

    initial begin
        #2000000;
        n_errors++;
        finish_test;
    end
endmodule // fast_adc_comb_decimator_path_test
